// file: hw/pulse_counter_defines.svh
// Register offsets, field positions and reset values of the pulse counter unit.
// Assumes an APB slave with byte addresses in paddr[7:0].
`ifndef PULSE_COUNTER_DEFINES_SVH
`define PULSE_COUNTER_DEFINES_SVH
`define OFS_CTRL 8'h00
`define OFS_SOURCE 8'h04
`define OFS_PERIOD 8'h08
`define OFS_VALUE 8'h0c
`define OFS_STAMP 8'h10
`define OFS_STATUS 8'h14
`define CTL_EN 0
`define CTL_MODE 2:1
`define CTL_INTEG 3
`define CTL_RISE 4
`define CTL_FALL 5
`define CTL_OP 7:6
`define CTL_BITS 8
`define SRC_PULSE 5:0
`define SRC_GATE 10:8
`define SRC_BITS 11
`define SRC_TRIG_BIT 5
`define RST_CTRL 8'h10
`define RST_SOURCE 11'h000
`define RST_PERIOD 32'h00000001
`define ZERO32 32'h00000000
`define ONE32 32'h00000001
`endif

// file: hw/pulse_counter_pkg.sv
// Types shared by the pulse counter unit.
// Assumes nothing of its surroundings.
package pulse_counter_pkg;
  typedef enum logic [1:0] {
    MODE_FREE = 2'b00,
    MODE_GATED_FREE = 2'b01,
    MODE_GATED = 2'b10,
    MODE_TAG = 2'b11
  } mode_e;
  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_ADD = 2'b01,
    OP_SUB = 2'b10
  } op_e;
  typedef enum logic {
    TAG_ARMED = 1'b0,
    TAG_HOLD = 1'b1
  } tag_state_e;
endpackage

// file: hw/pulse_counter_unit.sv
// Pulse counter unit: APB registers, pulse and gate selection, four run modes,
// pairing arithmetic, integration and a result stream.
// Assumes APB and partner inputs synchronous to pclk; pulse and gate lines are synchronised here; the partner unit shares pclk.
`timescale 1ns/1ps
`include "pulse_counter_defines.svh"

// Operation
// - see: nothing counts or streams while disabled
// - see: pulse source is 32 lines or 4 triggers
// - see: gate from four triggers or four generator triggers
// - see: free mode clears each period, outputs count
// - see: gated free holds count and timer while low; the code clears both while the gate is low
// - see: gated free outputs only after full high period
// - see: gated mode counts between gate rise and fall
// - see: gated mode outputs count at gate fall
// - see: time tagging reports each pulse with timestamp
// - see: period is minimum hold-off between tag reports
// - see: pulses in hold-off window reported together afterward
// - see: one period setting serves all timed modes
// - see: operation none, add or subtract partner result
// - see: units pair one-two and three-four for arithmetic
// - see: integration sums successive results over time
// - see: rising setting counts low-to-high transitions
// - see: falling setting counts high-to-low; both counts both
// - see: results streamed and last result readable
module pulse_counter_unit (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] port_line_in,
  input wire logic [3:0] front_trigger_in,
  input wire logic [3:0] generator_trigger_in,
  input wire logic partner_valid,
  input wire logic [31:0] partner_data,
  output logic pair_valid,
  output logic [31:0] pair_data,
  output logic res_valid,
  output logic [31:0] res_data,
  output logic [31:0] res_stamp
);
  function automatic logic edge_seen(input logic cur, input logic prev, input logic want_hi);
    edge_seen = want_hi ? (cur & ~prev) : (~cur & prev);
  endfunction

  logic [`CTL_BITS-1:0] ctrl_r;
  logic [`SRC_BITS-1:0] src_r;
  logic [31:0] period_r;
  logic [31:0] value_r;
  logic [31:0] stamp_r;
  logic [31:0] nres_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic p1_r, p2_r, p3_r;
  logic g1_r, g2_r, g3_r;
  logic [31:0] cnt_r, cnt_nxt;
  logic [31:0] tmr_r, tmr_nxt;
  logic [31:0] tnow_r;
  logic [31:0] acc_r;
  logic [31:0] part_r;
  logic [31:0] res_data_r;
  logic [31:0] res_stamp_r;
  logic res_valid_r;
  logic [31:0] pair_data_r;
  logic pair_valid_r;
  logic raw_v;
  logic [31:0] raw_d;
  pulse_counter_pkg::tag_state_e tag_r, tag_nxt;

  // APB decode; writes land only in the access cycle the slave acknowledges
  wire setup = psel & ~penable & ~pready_r;
  wire acc_wr = psel & penable & pwrite & pready_r;
  wire hit_ctrl = paddr == `OFS_CTRL;
  wire hit_src = paddr == `OFS_SOURCE;
  wire hit_per = paddr == `OFS_PERIOD;
  wire mapped = hit_ctrl | hit_src | hit_per | (paddr == `OFS_VALUE)
    | (paddr == `OFS_STAMP) | (paddr == `OFS_STATUS);
  wire cfg_wr = acc_wr & (hit_ctrl | hit_src | hit_per);
  wire [31:0] rd_mux = hit_ctrl ? {24'h000000, ctrl_r} :
    hit_src ? {21'h000000, src_r} :
    hit_per ? period_r :
    (paddr == `OFS_VALUE) ? value_r :
    (paddr == `OFS_STAMP) ? stamp_r :
    (paddr == `OFS_STATUS) ? nres_r : `ZERO32;

  wire en = ctrl_r[`CTL_EN];
  wire integ = ctrl_r[`CTL_INTEG];
  wire [1:0] mode_w = ctrl_r[`CTL_MODE];
  wire [1:0] op_w = ctrl_r[`CTL_OP];
  wire [5:0] psel_w = src_r[`SRC_PULSE];
  wire [2:0] gsel_w = src_r[`SRC_GATE];

  // Selection ahead of the synchroniser; a selection change clears the counters anyway
  wire pulse_raw = psel_w[`SRC_TRIG_BIT] ? front_trigger_in[psel_w[1:0]]
    : port_line_in[psel_w[4:0]];
  wire gate_raw = gsel_w[2] ? generator_trigger_in[gsel_w[1:0]]
    : front_trigger_in[gsel_w[1:0]];

  wire ev_rise = ctrl_r[`CTL_RISE] & edge_seen(p2_r, p3_r, 1'b1);
  wire ev_fall = ctrl_r[`CTL_FALL] & edge_seen(p2_r, p3_r, 1'b0);
  wire ev = ev_rise | ev_fall;
  wire gate_s = g2_r;
  wire gate_rise = edge_seen(g2_r, g3_r, 1'b1);
  wire gate_fall = edge_seen(g2_r, g3_r, 1'b0);

  // A period of zero behaves as one cycle
  wire [31:0] period_m1 = (period_r == `ZERO32) ? `ZERO32 : period_r - `ONE32;
  wire tmr_end = tmr_r >= period_m1;
  wire [31:0] cnt_inc = cnt_r + {31'h00000000, ev};
  wire [31:0] tmr_inc = tmr_r + `ONE32;
  wire [31:0] sum_w = raw_d + part_r;
  wire [31:0] dif_w = raw_d - part_r;
  wire [31:0] comb_d = (op_w == pulse_counter_pkg::OP_ADD) ? sum_w :
    (op_w == pulse_counter_pkg::OP_SUB) ? dif_w : raw_d;
  wire [31:0] acc_nxt = acc_r + comb_d;
  wire [31:0] out_d = integ ? acc_nxt : comb_d;

  always_comb begin
    cnt_nxt = cnt_r;
    tmr_nxt = tmr_r;
    tag_nxt = tag_r;
    raw_v = 1'b0;
    raw_d = cnt_inc;
    if (!en || cfg_wr) begin
      cnt_nxt = `ZERO32;
      tmr_nxt = `ZERO32;
      tag_nxt = pulse_counter_pkg::TAG_ARMED;
    end else begin
      case (mode_w)
        pulse_counter_pkg::MODE_FREE: begin
          if (tmr_end) begin
            raw_v = 1'b1;
            cnt_nxt = `ZERO32;
            tmr_nxt = `ZERO32;
          end else begin
            cnt_nxt = cnt_inc;
            tmr_nxt = tmr_inc;
          end
        end
        pulse_counter_pkg::MODE_GATED_FREE: begin
          if (!gate_s) begin
            cnt_nxt = `ZERO32;
            tmr_nxt = `ZERO32;
          end else if (tmr_end) begin
            raw_v = 1'b1;
            cnt_nxt = `ZERO32;
            tmr_nxt = `ZERO32;
          end else begin
            cnt_nxt = cnt_inc;
            tmr_nxt = tmr_inc;
          end
        end
        pulse_counter_pkg::MODE_GATED: begin
          if (gate_rise) begin
            cnt_nxt = {31'h00000000, ev};
          end else if (gate_fall) begin
            raw_v = 1'b1;
            raw_d = cnt_r;
            cnt_nxt = `ZERO32;
          end else if (gate_s) begin
            cnt_nxt = cnt_inc;
          end
        end
        pulse_counter_pkg::MODE_TAG: begin
          if (tag_r == pulse_counter_pkg::TAG_ARMED) begin
            if (ev) begin
              raw_v = 1'b1;
              raw_d = `ONE32;
              cnt_nxt = `ZERO32;
              tmr_nxt = `ZERO32;
              tag_nxt = pulse_counter_pkg::TAG_HOLD;
            end
          end else if (tmr_end) begin
            // A late report restarts the hold-off so spacing never drops below a period
            raw_v = cnt_inc != `ZERO32;
            cnt_nxt = `ZERO32;
            tmr_nxt = `ZERO32;
            tag_nxt = (cnt_inc != `ZERO32) ? pulse_counter_pkg::TAG_HOLD
              : pulse_counter_pkg::TAG_ARMED;
          end else begin
            cnt_nxt = cnt_inc;
            tmr_nxt = tmr_inc;
          end
        end
        default: begin
          cnt_nxt = `ZERO32;
          tmr_nxt = `ZERO32;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= `ZERO32;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup & ~mapped;
      prdata_r <= setup ? rd_mux : `ZERO32;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `RST_CTRL;
      src_r <= `RST_SOURCE;
      period_r <= `RST_PERIOD;
    end else if (acc_wr) begin
      if (hit_ctrl) ctrl_r <= pwdata[`CTL_BITS-1:0];
      if (hit_src) src_r <= pwdata[`SRC_BITS-1:0];
      if (hit_per) period_r <= pwdata;
    end
  end

  // Two-flop synchronisers; the third stage only serves edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {p1_r, p2_r, p3_r} <= 3'h0;
      {g1_r, g2_r, g3_r} <= 3'h0;
    end else begin
      {p1_r, p2_r, p3_r} <= {pulse_raw, p1_r, p2_r};
      {g1_r, g2_r, g3_r} <= {gate_raw, g1_r, g2_r};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= `ZERO32;
      tmr_r <= `ZERO32;
      tag_r <= pulse_counter_pkg::TAG_ARMED;
      tnow_r <= `ZERO32;
    end else begin
      cnt_r <= cnt_nxt;
      tmr_r <= tmr_nxt;
      tag_r <= tag_nxt;
      tnow_r <= tnow_r + `ONE32;
    end
  end

  // Partner result latched as it appears; pairs are wired at the level above
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      part_r <= `ZERO32;
    end else if (!en) begin
      part_r <= `ZERO32;
    end else if (partner_valid) begin
      part_r <= partner_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r <= `ZERO32;
    end else if (!en || cfg_wr) begin
      acc_r <= `ZERO32;
    end else if (raw_v && integ) begin
      acc_r <= acc_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_valid_r <= 1'b0;
      res_data_r <= `ZERO32;
      res_stamp_r <= `ZERO32;
      pair_valid_r <= 1'b0;
      pair_data_r <= `ZERO32;
      value_r <= `ZERO32;
      stamp_r <= `ZERO32;
      nres_r <= `ZERO32;
    end else begin
      res_valid_r <= raw_v;
      pair_valid_r <= raw_v;
      if (raw_v) begin
        res_data_r <= out_d;
        res_stamp_r <= tnow_r;
        pair_data_r <= raw_d;
        value_r <= out_d;
        stamp_r <= tnow_r;
        nres_r <= nres_r + `ONE32;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign res_valid = res_valid_r;
  assign res_data = res_data_r;
  assign res_stamp = res_stamp_r;
  assign pair_valid = pair_valid_r;
  assign pair_data = pair_data_r;

  wire run_free = en & ~cfg_wr & (mode_w == pulse_counter_pkg::MODE_FREE);
  wire run_gfree = en & ~cfg_wr & (mode_w == pulse_counter_pkg::MODE_GATED_FREE);
  wire run_gated = en & ~cfg_wr & (mode_w == pulse_counter_pkg::MODE_GATED);
  wire run_tag = en & ~cfg_wr & (mode_w == pulse_counter_pkg::MODE_TAG);
  wire armed = tag_r == pulse_counter_pkg::TAG_ARMED;
  wire op_add_plain = (op_w == pulse_counter_pkg::OP_ADD) & ~integ;

  property p_off_silent;
    @(posedge pclk) disable iff (!presetn) !en |=> !res_valid_r;
  endproperty
  a_off_silent: assert property (p_off_silent) else $error("result while disabled");

  property p_free_period;
    @(posedge pclk) disable iff (!presetn)
      run_free && tmr_end |=> res_valid_r && cnt_r == `ZERO32 && tmr_r == `ZERO32;
  endproperty
  a_free_period: assert property (p_free_period) else $error("free period end wrong");

  property p_gfree_low;
    @(posedge pclk) disable iff (!presetn)
      run_gfree && !gate_s |=> cnt_r == `ZERO32 && tmr_r == `ZERO32 && !res_valid_r;
  endproperty
  a_gfree_low: assert property (p_gfree_low) else $error("gate low did not clear");

  property p_gated_count;
    @(posedge pclk) disable iff (!presetn)
      run_gated && gate_s && !gate_rise && ev |=> cnt_r == $past(cnt_r) + `ONE32;
  endproperty
  a_gated_count: assert property (p_gated_count) else $error("gated pulse lost");

  property p_gated_out;
    @(posedge pclk) disable iff (!presetn)
      run_gated && gate_fall |=> res_valid_r && pair_data_r == $past(cnt_r);
  endproperty
  a_gated_out: assert property (p_gated_out) else $error("no result at gate fall");

  property p_tag_stamp;
    @(posedge pclk) disable iff (!presetn)
      run_tag && armed && ev |=> res_valid_r && res_stamp_r == $past(tnow_r);
  endproperty
  a_tag_stamp: assert property (p_tag_stamp) else $error("tag not stamped");

  property p_tag_holdoff;
    @(posedge pclk) disable iff (!presetn)
      en && !armed && !tmr_end |=> !res_valid_r;
  endproperty
  a_tag_holdoff: assert property (p_tag_holdoff) else $error("report inside hold-off");

  property p_add;
    @(posedge pclk) disable iff (!presetn)
      raw_v && op_add_plain |=> res_data_r == $past(sum_w);
  endproperty
  a_add: assert property (p_add) else $error("partner sum wrong");

  property p_readback;
    @(posedge pclk) disable iff (!presetn) res_valid_r |-> value_r == res_data_r;
  endproperty
  a_readback: assert property (p_readback) else $error("value differs from stream");

  property p_cfg_clear;
    @(posedge pclk) disable iff (!presetn)
      cfg_wr |=> cnt_r == `ZERO32 && tmr_r == `ZERO32 && !res_valid_r;
  endproperty
  a_cfg_clear: assert property (p_cfg_clear) else $error("config change kept count");
endmodule

// file: testbench/pulse_source.sv
// Far-side model: pulse trains and gate levels on the port lines and triggers.
// Assumes the bench picks one pulse line and one gate line through its inputs.
`timescale 1ns/1ps
module pulse_source (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [5:0] pulse_sel,
  input wire logic gate_on,
  input wire logic [2:0] gate_sel,
  output logic [31:0] port_line_in,
  output logic [3:0] front_trigger_in,
  output logic [3:0] generator_trigger_in
);
  logic [1:0] ph_r;
  logic gate_r;
  logic [39:0] lines;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_r <= 2'h0;
      gate_r <= 1'b0;
    end else begin
      ph_r <= ph_r + 2'h1;
      // Gate moves off the pulse edges, so a gate window holds whole pulses
      if (!ph_r[0]) begin
        gate_r <= gate_on;
      end
    end
  end
  always_comb begin
    // Unselected lines toggle twice as fast, so a wrong selection miscounts
    lines = {40{ph_r[0]}};
    lines[6'd32 + 6'(gate_sel)] = gate_r;
    if (run) begin
      lines[pulse_sel] = ph_r[1];
    end
  end
  assign port_line_in = lines[31:0];
  assign front_trigger_in = lines[35:32];
  assign generator_trigger_in = lines[39:36];
endmodule

// file: testbench/tb.sv
// Testbench for the pulse counter unit: APB tasks and run-mode scenarios.
// Assumes pulse_source drives the lines with a 4-cycle pulse train.
`timescale 1ns/1ps
`include "pulse_counter_defines.svh"
module tb;
  logic pclk, presetn, psel, penable, pwrite, pv, pair_valid, res_valid, pready, pslverr;
  logic run, gate_on;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, pd, pair_data, res_data, res_stamp, port_line_in;
  logic [3:0] front_trigger_in, generator_trigger_in;
  logic [5:0] psrc;
  logic [2:0] gsel;
  logic [5:0] srcs [5] = '{6'd0, 6'd5, 6'd31, 6'd32, 6'd35};
  logic [31:0] opx [4] = '{32'h5, 32'h69, 32'hffffffa1, 32'h5};
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  int nres = 0;
  pulse_counter_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_line_in(port_line_in), .front_trigger_in(front_trigger_in),
    .generator_trigger_in(generator_trigger_in), .partner_valid(pv), .partner_data(pd),
    .pair_valid(pair_valid), .pair_data(pair_data), .res_valid(res_valid),
    .res_data(res_data), .res_stamp(res_stamp));
  pulse_source src (.pclk(pclk), .presetn(presetn), .run(run), .pulse_sel(psrc),
    .gate_on(gate_on), .gate_sel(gsel), .port_line_in(port_line_in),
    .front_trigger_in(front_trigger_in), .generator_trigger_in(generator_trigger_in));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;
  always @(negedge pclk) if (res_valid === 1'b1) nres <= nres + 1;
  task automatic wrap_up();
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 40);
    if (pready !== 1'b1) begin
      error_cnt++;
      wrap_up();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
  endtask
  task automatic getr(output logic [31:0] d, output int t, output logic [31:0] s);
    for (int i = 0; i < 400; i++) begin
      @(negedge pclk);
      if (res_valid === 1'b1) begin
        d = res_data;
        t = cyc;
        s = res_stamp;
        return;
      end
    end
    error_cnt++;
    wrap_up();
  endtask
  // x holds op[1:0], falling, rising, integrate
  task automatic cfg(input logic [1:0] m, input logic [4:0] x, input logic [5:0] s,
      input logic [2:0] g, input logic [31:0] p);
    @(posedge pclk);
    psrc <= s;
    gsel <= g;
    wr(`OFS_SOURCE, {21'h0, g, 2'h0, s});
    wr(`OFS_PERIOD, p);
    wr(`OFS_CTRL, {24'h0, x, m, 1'b1});
  endtask
  initial begin
    repeat (60000) @(posedge pclk);
    error_cnt++;
    wrap_up();
  end
  initial begin
    logic [31:0] d, d2, s, s2;
    logic e;
    int t, t2, t0, k;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pv = 1'b0;
    pd = 32'h0;
    run = 1'b1;
    gate_on = 1'b0;
    psrc = 6'd5;
    gsel = 3'd7;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`OFS_CTRL, 32'h10);
    rdc(`OFS_PERIOD, 32'h1);
    apb(1'b0, 8'h18, 32'h0, d, e);
    chk({31'h0, e}, 32'h1);
    wr(`OFS_PERIOD, 32'd20);
    repeat (100) @(posedge pclk);
    chk(32'(nres), 32'h0);
    for (k = 0; k < 5; k++) begin
      cfg(pulse_counter_pkg::MODE_FREE, 5'b00010, srcs[k], 3'd7, 32'd20);
      getr(d, t, s);
      getr(d, t, s);
      getr(d2, t2, s2);
      chk(d2, 32'h5);
      chk(32'(t2 - t), 32'd20);
      chk(s2 - s, 32'd20);
    end
    for (k = 1; k < 4; k++) begin
      cfg(pulse_counter_pkg::MODE_FREE, {2'b00, k[1:0], 1'b0}, 6'd7, 3'd7, 32'd20);
      getr(d, t, s);
      getr(d, t, s);
      chk(d, (k == 3) ? 32'ha : 32'h5);
    end
    for (k = 0; k < 8; k++) begin
      cfg(pulse_counter_pkg::MODE_GATED, 5'b00010, 6'd3, k[2:0], 32'd20);
      repeat (10) @(posedge pclk);
      gate_on <= 1'b1;
      repeat (40) @(posedge pclk);
      gate_on <= 1'b0;
      t0 = cyc;
      getr(d, t, s);
      chk(d, 32'ha);
      chk(32'(t - t0 < 8), 32'h1);
    end
    cfg(pulse_counter_pkg::MODE_GATED_FREE, 5'b00010, 6'd3, 3'd4, 32'd20);
    k = nres;
    gate_on <= 1'b1;
    repeat (16) @(posedge pclk);
    gate_on <= 1'b0;
    repeat (30) @(posedge pclk);
    chk(32'(nres - k), 32'h0);
    gate_on <= 1'b1;
    t0 = cyc;
    getr(d, t, s);
    chk(d, 32'h5);
    chk(32'(t - t0 > 20), 32'h1);
    @(posedge pclk);
    gate_on <= 1'b0;
    cfg(pulse_counter_pkg::MODE_TAG, 5'b00010, 6'd9, 3'd7, 32'd20);
    getr(d, t, s);
    chk(d, 32'h1);
    getr(d2, t2, s2);
    chk(s2 - s, 32'(t2 - t));
    chk(32'(t2 - t >= 20), 32'h1);
    chk(32'(d2 >= 5 && d2 <= 6), 32'h1);
    for (k = 0; k < 4; k++) begin
      cfg(pulse_counter_pkg::MODE_FREE, {k[1:0], 3'b010}, 6'd7, 3'd7, 32'd20);
      pv <= 1'b1;
      pd <= 32'h64;
      @(posedge pclk);
      pv <= 1'b0;
      getr(d, t, s);
      getr(d, t, s);
      chk(d, opx[k]);
      chk(pair_data, 32'h5);
      chk({31'h0, pair_valid}, 32'h1);
    end
    cfg(pulse_counter_pkg::MODE_FREE, 5'b00011, 6'd7, 3'd7, 32'd20);
    getr(d, t, s);
    getr(d2, t2, s2);
    chk(d2 - d, 32'h5);
    wr(`OFS_VALUE, 32'h1234);
    rdc(`OFS_VALUE, d2);
    rdc(`OFS_STAMP, s2);
    rdc(`OFS_STATUS, 32'(nres));
    cfg(pulse_counter_pkg::MODE_FREE, 5'b00010, 6'd7, 3'd7, 32'd20);
    getr(d, t, s);
    repeat (7) @(posedge pclk);
    wr(`OFS_PERIOD, 32'd12);
    getr(d, t, s);
    chk(d, 32'h3);
    wrap_up();
  end
endmodule
